// [pkg/diode_ctrl_pkg.sv]
// Constants and state encodings for the thermal diode emulation and ZVS detect block.
// Assumes a single 50 MHz core clock; all times below are converted to cycles here.
package diode_ctrl_pkg;

  // Core clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;

  // Width of every internal down counter and of the reverse conduction timer.
  localparam int CNT_W = 8;

  // Blanking after a gate command falling edge while in hot diode emulation (least time).
  localparam int BLANK_TIME_NS = 200;
  localparam int BLANK_CYCLES  = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Delay from ZVS recognition to the start of the pulse, and the pulse width (least times).
  localparam int ZVS_DELAY_NS     = 60;
  localparam int ZVS_DELAY_CYCLES = (ZVS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZVS_WIDTH_NS     = 100;
  localparam int ZVS_WIDTH_CYCLES = (ZVS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Minimum reverse conduction time per drive strength code (0 is the strongest drive).
  localparam int MIN_REV_NS_0 = 40;
  localparam int MIN_REV_NS_1 = 60;
  localparam int MIN_REV_NS_2 = 80;
  localparam int MIN_REV_NS_3 = 120;
  localparam int MIN_REV_CYC_0 = (MIN_REV_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_REV_CYC_1 = (MIN_REV_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_REV_CYC_2 = (MIN_REV_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_REV_CYC_3 = (MIN_REV_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Number of pin inputs passing through the synchroniser.
  localparam int SYNC_W = 11;

  // Start-up sequencing: lockout, rails ramping, running.
  typedef enum logic [1:0] {P_OFF, P_RAMP, P_RUN} power_state_type;

  // Hot diode emulation states: blanking, watching for reverse drain voltage, conducting.
  typedef enum logic [1:0] {H_BLANK, H_WATCH, H_COND} hot_state_type;

  // Zero-volt pulse generator phases.
  typedef enum logic [1:0] {Z_IDLE, Z_DELAY, Z_PULSE} pulse_state_type;

endpackage

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; multi-bit codes may skew by one cycle.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta  <= '0;
      level <= '0;
    end else begin
      meta  <= pin;
      level <= meta;
    end
  end

endmodule

`default_nettype wire

// [rtl/thermal_diode_emulation_zvs_detect.sv]
// Power switch control: start-up sequencing, hot diode emulation and ZVS pulse output.
// Assumes all sensor and command inputs are asynchronous pins and the core clock is 50 MHz.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - In hot emulation, every gate falling edge forces the blanking state and switch off.
// - Blanking holds the switch off for a fixed time, then moves to watching.
// - Blanking never waits for a positive drain voltage, so it cannot stick.
// - Watching keeps the switch off and moves to conducting on negative drain voltage.
// - Entering thermal shutdown starts emulation in the watching state.
// - Conducting turns the switch on; forward current returns to watching, switch off.
// - Without gate activity the machine only moves between watching and conducting.
// - Repeated shoot-through is neither counted nor locked out; each edge restarts.
// - Each gate rising edge while running with the pulse generator idle checks whether drain voltage had gone below zero.
// - A recognised ZVS gives one pulse, after the pulse delay, lasting the pulse width.
// - Reverse conduction shorter than the minimum time gives no pulse.
// - Hard or partial hard switching gives no pulse.
// - Minimum reverse conduction time depends on the drive strength setting.
// - The fault output is low from the start of the supply ramp.
// - Rails start above lockout, stop below it, and restart on the next rise.
// - Fault is released and gate following starts only when both rails are ready.
// - Fault stays low in thermal shutdown and releases when both sensors cool.
// - Driver overheating disables emulation and keeps the switch off.
module thermal_diode_emulation_zvs_detect #(
  parameter int unsigned BLANK_CYCLES     = diode_ctrl_pkg::BLANK_CYCLES,
  parameter int unsigned ZVS_DELAY_CYCLES = diode_ctrl_pkg::ZVS_DELAY_CYCLES,
  parameter int unsigned ZVS_WIDTH_CYCLES = diode_ctrl_pkg::ZVS_WIDTH_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       gate_cmd,
  input  wire logic       vdd_above_rise,
  input  wire logic       vdd_below_fall,
  input  wire logic       aux_5v_rail_ok,
  input  wire logic       negative_bias_rail_ok,
  input  wire logic       fet_hot,
  input  wire logic       driver_hot,
  input  wire logic       drain_negative,
  input  wire logic       first_quadrant,
  input  wire logic [1:0] drive_strength,
  output logic            fet_on,
  output logic            rails_enable,
  output logic            fault_n,
  output logic            zero_volt_pulse_output
);

  localparam int CW = diode_ctrl_pkg::CNT_W;

  // Cycle figures used as assertion bounds.
  localparam int A_DLY    = ZVS_DELAY_CYCLES;
  localparam int A_WID_M1 = ZVS_WIDTH_CYCLES - 1;

  // Whole state of the block in one record.
  typedef struct packed {
    diode_ctrl_pkg::power_state_type pwr;
    diode_ctrl_pkg::hot_state_type   hot;
    diode_ctrl_pkg::pulse_state_type zph;
    logic [CW-1:0]                   blank_cnt;
    logic [CW-1:0]                   rev_cnt;
    logic [CW-1:0]                   zcnt;
    logic                            gate_prev;
    logic                            fet_on;
    logic                            fault_n;
    logic                            zv_out;
    logic                            rails_en;
  } ctrl_state_type;

  // Everything off and fault asserted while reset (undervoltage lockout) is held.
  localparam ctrl_state_type RESET_STATE = '{
    pwr:       diode_ctrl_pkg::P_OFF,
    hot:       diode_ctrl_pkg::H_WATCH,
    zph:       diode_ctrl_pkg::Z_IDLE,
    blank_cnt: '0,
    rev_cnt:   '0,
    zcnt:      '0,
    gate_prev: 1'b0,
    fet_on:    1'b0,
    fault_n:   1'b0,
    zv_out:    1'b0,
    rails_en:  1'b0
  };

  ctrl_state_type st;
  ctrl_state_type next_st;

  logic [diode_ctrl_pkg::SYNC_W-1:0] sync_q;
  logic                              gate_s;
  logic                              vdd_above_s;
  logic                              vdd_below_s;
  logic                              aux_ok_s;
  logic                              neg_ok_s;
  logic                              fet_hot_s;
  logic                              driver_hot_s;
  logic                              drain_neg_s;
  logic                              first_q_s;
  logic [1:0]                        strength_s;
  logic                              gate_rise;
  logic                              gate_fall;
  logic                              running;
  logic                              emul;
  logic                              rev_ok;
  logic                              zvs_seen;
  logic [CW-1:0]                     min_rev;

  // Every pin crosses into the core clock through two flip-flops first.
  pin_sync #(
    .WIDTH (diode_ctrl_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      ({strength_sel_pins(drive_strength), first_quadrant, drain_negative,
                driver_hot, fet_hot, negative_bias_rail_ok, aux_5v_rail_ok,
                vdd_below_fall, vdd_above_rise, gate_cmd}),
    .level    (sync_q)
  );

  // Identity helper keeps the pin concatenation readable.
  function automatic logic [1:0] strength_sel_pins(input logic [1:0] s);
    strength_sel_pins = s;
  endfunction

  // Unpack the synchronised levels.
  assign {strength_s, first_q_s, drain_neg_s, driver_hot_s, fet_hot_s, neg_ok_s,
          aux_ok_s, vdd_below_s, vdd_above_s, gate_s} = sync_q;

  // Edges come from the synchronised level against its own registered copy.
  assign gate_rise = gate_s && !st.gate_prev;
  assign gate_fall = !gate_s && st.gate_prev;

  assign running = (st.pwr == diode_ctrl_pkg::P_RUN);

  // Emulation runs only with the switch hot and the driver cool.
  assign emul = running && fet_hot_s && !driver_hot_s;

  // Minimum reverse conduction per drive strength; weaker drive needs longer.
  function automatic logic [CW-1:0] min_rev_cycles(input logic [1:0] s);
    case (s)
      2'h0:    min_rev_cycles = CW'(diode_ctrl_pkg::MIN_REV_CYC_0);
      2'h1:    min_rev_cycles = CW'(diode_ctrl_pkg::MIN_REV_CYC_1);
      2'h2:    min_rev_cycles = CW'(diode_ctrl_pkg::MIN_REV_CYC_2);
      default: min_rev_cycles = CW'(diode_ctrl_pkg::MIN_REV_CYC_3);
    endcase
  endfunction

  assign min_rev = min_rev_cycles(strength_s);

  // ZVS counts only if reverse conduction lasted right up to the rising edge.
  assign rev_ok   = (st.rev_cnt >= min_rev);
  assign zvs_seen = running && gate_rise && rev_ok && (st.zph == diode_ctrl_pkg::Z_IDLE);

  // Next-state logic for the whole block.
  always_comb begin
    next_st           = st;
    next_st.gate_prev = gate_s;

    // Start-up: lockout, ramp the rails, run once both rails are good.
    case (st.pwr)
      diode_ctrl_pkg::P_OFF: begin
        if (vdd_above_s) begin
          next_st.pwr = diode_ctrl_pkg::P_RAMP;
        end
      end
      diode_ctrl_pkg::P_RAMP: begin
        if (vdd_below_s) begin
          next_st.pwr = diode_ctrl_pkg::P_OFF;
        end else if (aux_ok_s && neg_ok_s) begin
          next_st.pwr = diode_ctrl_pkg::P_RUN;
        end
      end
      diode_ctrl_pkg::P_RUN: begin
        if (vdd_below_s) begin
          next_st.pwr = diode_ctrl_pkg::P_OFF;
        end
      end
      default: next_st.pwr = diode_ctrl_pkg::P_OFF;
    endcase
    next_st.rails_en = (next_st.pwr != diode_ctrl_pkg::P_OFF);

    // Outside emulation the machine parks in watching, so entry starts there.
    if (!emul) begin
      next_st.hot       = diode_ctrl_pkg::H_WATCH;
      next_st.blank_cnt = '0;
    end else if (gate_fall) begin
      // Any state yields to a falling edge; nothing is counted or locked out.
      next_st.hot       = diode_ctrl_pkg::H_BLANK;
      next_st.blank_cnt = CW'(BLANK_CYCLES);
    end else begin
      case (st.hot)
        // Fixed blanking, no drain voltage condition, so it always ends.
        diode_ctrl_pkg::H_BLANK: begin
          if (st.blank_cnt <= CW'(1)) begin
            next_st.hot = diode_ctrl_pkg::H_WATCH;
          end else begin
            next_st.blank_cnt = st.blank_cnt - CW'(1);
          end
        end
        // Reverse voltage means third-quadrant current: conduct.
        diode_ctrl_pkg::H_WATCH: begin
          if (drain_neg_s) begin
            next_st.hot = diode_ctrl_pkg::H_COND;
          end
        end
        // Forward current must be blocked again.
        diode_ctrl_pkg::H_COND: begin
          if (first_q_s) begin
            next_st.hot = diode_ctrl_pkg::H_WATCH;
          end
        end
        default: next_st.hot = diode_ctrl_pkg::H_WATCH;
      endcase
    end

    // Gate drive: emulation decides when hot, the command when cool, off otherwise.
    if (!running || driver_hot_s) begin
      next_st.fet_on = 1'b0;
    end else if (fet_hot_s) begin
      next_st.fet_on = (next_st.hot == diode_ctrl_pkg::H_COND);
    end else begin
      next_st.fet_on = gate_s;
    end

    // Fault is released only when running and both sensors are cool.
    next_st.fault_n = (next_st.pwr == diode_ctrl_pkg::P_RUN) && !fet_hot_s && !driver_hot_s;

    // Reverse conduction timer; it saturates and clears whenever the drain leaves negative.
    if (drain_neg_s && !gate_s) begin
      if (st.rev_cnt != '1) begin
        next_st.rev_cnt = st.rev_cnt + CW'(1);
      end
    end else begin
      next_st.rev_cnt = '0;
    end

    // Pulse generator; a new recognition during a pulse is dropped, not queued.
    case (st.zph)
      diode_ctrl_pkg::Z_IDLE: begin
        if (zvs_seen) begin
          next_st.zph  = diode_ctrl_pkg::Z_DELAY;
          next_st.zcnt = CW'(ZVS_DELAY_CYCLES);
        end
      end
      diode_ctrl_pkg::Z_DELAY: begin
        if (st.zcnt <= CW'(1)) begin
          next_st.zph    = diode_ctrl_pkg::Z_PULSE;
          next_st.zcnt   = CW'(ZVS_WIDTH_CYCLES);
          next_st.zv_out = 1'b1;
        end else begin
          next_st.zcnt = st.zcnt - CW'(1);
        end
      end
      diode_ctrl_pkg::Z_PULSE: begin
        if (st.zcnt <= CW'(1)) begin
          next_st.zph    = diode_ctrl_pkg::Z_IDLE;
          next_st.zv_out = 1'b0;
        end else begin
          next_st.zcnt = st.zcnt - CW'(1);
        end
      end
      default: begin
        next_st.zph    = diode_ctrl_pkg::Z_IDLE;
        next_st.zv_out = 1'b0;
      end
    endcase
  end

  // One register for the whole state; reset is the lockout condition.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // All outputs come straight from flip-flops.
  assign fet_on                 = st.fet_on;
  assign rails_enable           = st.rails_en;
  assign fault_n                = st.fault_n;
  assign zero_volt_pulse_output = st.zv_out;

  // Assertions watch the design's own state and outputs.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // A falling edge while emulating lands in blanking with the switch off.
  chk_fall_blank: assert property (
    emul && gate_fall |=> st.hot == diode_ctrl_pkg::H_BLANK && !fet_on
  ) else $error("falling edge did not force blanking");

  // The last blanking cycle always moves on to watching.
  chk_blank_end: assert property (
    emul && !gate_fall && st.hot == diode_ctrl_pkg::H_BLANK && st.blank_cnt == CW'(1)
    |=> st.hot == diode_ctrl_pkg::H_WATCH && !fet_on
  ) else $error("blanking did not end on time");

  // Negative drain voltage while watching turns the switch on next.
  chk_watch_cond: assert property (
    emul && !gate_fall && st.hot == diode_ctrl_pkg::H_WATCH && drain_neg_s
    |=> st.hot == diode_ctrl_pkg::H_COND && fet_on
  ) else $error("watching missed reverse voltage");

  // Emulation always begins in watching.
  chk_entry_watch: assert property (
    $rose(emul) |-> st.hot == diode_ctrl_pkg::H_WATCH
  ) else $error("emulation did not start in watching");

  // Forward current while conducting switches off.
  chk_cond_exit: assert property (
    emul && !gate_fall && st.hot == diode_ctrl_pkg::H_COND && first_q_s
    |=> st.hot == diode_ctrl_pkg::H_WATCH && !fet_on
  ) else $error("conducting state ignored forward current");

  // Blanking is reached only through a falling edge.
  chk_blank_cause: assert property (
    emul && !gate_fall && st.hot != diode_ctrl_pkg::H_BLANK
    |=> st.hot != diode_ctrl_pkg::H_BLANK
  ) else $error("blanking entered without a falling edge");

  // Recognition, then exactly the delay, then the pulse of exactly the width.
  sequence zvs_recognised;
    zvs_seen;
  endsequence

  sequence pulse_after_delay;
    ##A_DLY !zero_volt_pulse_output ##1 zero_volt_pulse_output;
  endsequence

  chk_zvs_delay: assert property (
    zvs_recognised |-> pulse_after_delay
  ) else $error("zero-volt pulse started at the wrong time");

  chk_zvs_width: assert property (
    $rose(zero_volt_pulse_output) |-> ##A_WID_M1 zero_volt_pulse_output
    ##1 !zero_volt_pulse_output
  ) else $error("zero-volt pulse has the wrong width");

  // A rising edge without enough reverse conduction starts no pulse.
  chk_hard_quiet: assert property (
    gate_rise && !rev_ok && st.zph == diode_ctrl_pkg::Z_IDLE
    |=> st.zph == diode_ctrl_pkg::Z_IDLE
  ) else $error("pulse started without reverse conduction");

  // Fault is high only when running with both sensors cool one cycle before.
  chk_fault_release: assert property (
    fault_n |-> running && $past(!fet_hot_s && !driver_hot_s)
  ) else $error("fault released too early");

  // Lockout drops the rails on the next cycle.
  chk_lockout_halt: assert property (
    st.pwr != diode_ctrl_pkg::P_OFF && vdd_below_s |=> !rails_enable
  ) else $error("rails not halted on lockout");

  // Driver overheating keeps the switch off.
  chk_driver_hot_off: assert property (
    driver_hot_s |=> !fet_on
  ) else $error("switch on while the driver is hot");

endmodule

`default_nettype wire

// [sim/controller_model.sv]
// Converter controller model: drives the gate command pin, counts zero-volt pulses.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module controller_model (
  input  wire logic core_clk,
  input  wire logic zero_volt_pulse_output,
  output var  logic gate_cmd
);
  int pulse_count = 0;
  int last_width  = 0;
  int run_len     = 0;

  // The pin starts low, so the switch stays off before the first command.
  initial begin
    gate_cmd = 1'b0;
  end

  // Sets the gate command level and holds it until the next call.
  task automatic set_gate(input logic level);
    gate_cmd = level;
  endtask

  // Toggles a hot device first, so that it runs through blanking.
  task automatic kick(input int high_cycles);
    gate_cmd = 1'b1;
    repeat (high_cycles) @(posedge core_clk);
    #2;
    gate_cmd = 1'b0;
  endtask

  // Measures every pulse in whole cycles at the falling edge, where the output has settled.
  // A pulse is counted when it ends.
  always @(negedge core_clk) begin
    if (zero_volt_pulse_output === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulse_count <= pulse_count + 1;
      last_width  <= run_len;
      run_len     <= 0;
    end
  end
endmodule

`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the diode emulation and zero-volt detect block.
// Assumes inputs change 2 ns after a rising edge and outputs settle by then.
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end

module testbench;
  // The block runs with its own defaults, so the expected times come from the package.
  localparam int unsigned BLANK = diode_ctrl_pkg::BLANK_CYCLES;
  localparam int unsigned DLY   = diode_ctrl_pkg::ZVS_DELAY_CYCLES;
  localparam int unsigned WID   = diode_ctrl_pkg::ZVS_WIDTH_CYCLES;

  typedef struct {
    logic [1:0] strength;
    int         neg;
    logic       pulse;
  } zvs_row_type;

  // Each strength is tried one cycle over and one under its minimum, so codes differ.
  zvs_row_type rows [9] = '{'{2'h0, 3, 1'b1}, '{2'h0, 1, 1'b0}, '{2'h1, 4, 1'b1},
                            '{2'h1, 2, 1'b0}, '{2'h2, 5, 1'b1}, '{2'h2, 3, 1'b0},
                            '{2'h3, 7, 1'b1}, '{2'h3, 5, 1'b0}, '{2'h0, 0, 1'b0}};

  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       gate_cmd;
  logic       vdd_above_rise = 1'b0;
  logic       vdd_below_fall = 1'b1;
  logic       aux_5v_rail_ok = 1'b0;
  logic       negative_bias_rail_ok = 1'b0;
  logic       fet_hot = 1'b0;
  logic       driver_hot = 1'b0;
  logic       drain_negative = 1'b0;
  logic       first_quadrant = 1'b0;
  logic [1:0] drive_strength = 2'h0;
  logic       fet_on;
  logic       rails_enable;
  logic       fault_n;
  logic       zero_volt_pulse_output;
  int         checks = 0;
  int         mismatches = 0;

  // The clock toggles every half period of 20 ns.
  always #10 core_clk = ~core_clk;

  thermal_diode_emulation_zvs_detect u_thermal_diode_emulation_zvs_detect (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .gate_cmd               (gate_cmd),
    .vdd_above_rise         (vdd_above_rise),
    .vdd_below_fall         (vdd_below_fall),
    .aux_5v_rail_ok         (aux_5v_rail_ok),
    .negative_bias_rail_ok  (negative_bias_rail_ok),
    .fet_hot                (fet_hot),
    .driver_hot             (driver_hot),
    .drain_negative         (drain_negative),
    .first_quadrant         (first_quadrant),
    .drive_strength         (drive_strength),
    .fet_on                 (fet_on),
    .rails_enable           (rails_enable),
    .fault_n                (fault_n),
    .zero_volt_pulse_output (zero_volt_pulse_output)
  );

  controller_model u_controller_model (
    .core_clk               (core_clk),
    .zero_volt_pulse_output (zero_volt_pulse_output),
    .gate_cmd               (gate_cmd)
  );

  // Advances n edges and lands 2 ns after the last; zero edges keeps the present time.
  task automatic step(input int n);
    if (n > 0) begin
      repeat (n) @(posedge core_clk);
      #2;
    end
  endtask

  // Waits a bounded number of cycles for the switch to reach a level.
  task automatic wait_on(input logic exp, input int lim);
    for (int i = 0; i < lim && fet_on !== exp; i++) begin
      step(1);
    end
    `CHK("fet_on wait", exp, fet_on)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run needs well under 1000 cycles; the limit leaves wide margin.
  initial begin
    #60000;
    mismatches++;
    summarize();
  end

  initial begin
    step(16);
    `CHK("fault_n in reset", 1'b0, fault_n)
    `CHK("rails in reset", 1'b0, rails_enable)
    sys_rst = 1'b0;
    step(3);
    // A supply glitch before the rails are up must stop the build-up.
    vdd_above_rise = 1'b1;
    vdd_below_fall = 1'b0;
    step(2);
    `CHK("rails early", 1'b0, rails_enable)
    step(1);
    `CHK("rails on", 1'b1, rails_enable)
    vdd_above_rise = 1'b0;
    vdd_below_fall = 1'b1;
    step(3);
    `CHK("rails glitch", 1'b0, rails_enable)
    vdd_below_fall = 1'b0;
    step(5);
    `CHK("rails no rise", 1'b0, rails_enable)
    vdd_above_rise = 1'b1;
    step(3);
    `CHK("rails again", 1'b1, rails_enable)
    aux_5v_rail_ok = 1'b1;
    step(5);
    `CHK("fault one rail", 1'b0, fault_n)
    negative_bias_rail_ok = 1'b1;
    step(2);
    `CHK("fault early", 1'b0, fault_n)
    step(1);
    `CHK("fault released", 1'b1, fault_n)
    u_controller_model.set_gate(1'b1);
    step(2);
    `CHK("follow early", 1'b0, fet_on)
    step(1);
    `CHK("follow on", 1'b1, fet_on)
    u_controller_model.set_gate(1'b0);
    step(3);
    `CHK("follow off", 1'b0, fet_on)
    // Ordinary cases: reverse conduction length against each strength code.
    foreach (rows[r]) begin
      drive_strength = rows[r].strength;
      step(6);
      drain_negative = (rows[r].neg > 0);
      step(rows[r].neg);
      u_controller_model.set_gate(1'b1);
      drain_negative = 1'b0;
      step(2 + DLY);
      `CHK("pulse before delay", 1'b0, zero_volt_pulse_output)
      step(1);
      `CHK("pulse start", rows[r].pulse, zero_volt_pulse_output)
      step(WID - 1);
      `CHK("pulse last", rows[r].pulse, zero_volt_pulse_output)
      step(1);
      `CHK("pulse end", 1'b0, zero_volt_pulse_output)
      u_controller_model.set_gate(1'b0);
    end
    step(2);
    `CHK("pulse count", 4, u_controller_model.pulse_count)
    `CHK("pulse width", WID, u_controller_model.last_width)
    // Hot emulation: enter, cycle as a diode, then shoot-through restarts.
    fet_hot = 1'b1;
    step(3);
    `CHK("fault hot", 1'b0, fault_n)
    drain_negative = 1'b1;
    step(2);
    `CHK("watch off", 1'b0, fet_on)
    step(1);
    `CHK("cond on", 1'b1, fet_on)
    first_quadrant = 1'b1;
    drain_negative = 1'b0;
    step(3);
    `CHK("forward off", 1'b0, fet_on)
    first_quadrant = 1'b0;
    step(2);
    drain_negative = 1'b1;
    step(3);
    `CHK("diode cycle", 1'b1, fet_on)
    u_controller_model.kick(3);
    `CHK("rise ignored", 1'b1, fet_on)
    step(3);
    `CHK("fall blanks", 1'b0, fet_on)
    step(1);
    u_controller_model.kick(2);
    step(3);
    `CHK("second fall", 1'b0, fet_on)
    step(BLANK - 1);
    `CHK("blank restarted", 1'b0, fet_on)
    wait_on(1'b1, 6);
    driver_hot = 1'b1;
    step(3);
    `CHK("driver hot off", 1'b0, fet_on)
    step(4);
    `CHK("driver hot hold", 1'b0, fet_on)
    `CHK("driver hot fault", 1'b0, fault_n)
    driver_hot = 1'b0;
    wait_on(1'b1, 8);
    fet_hot = 1'b0;
    drain_negative = 1'b0;
    step(3);
    `CHK("fault cooled", 1'b1, fault_n)
    sys_rst = 1'b1;
    step(1);
    `CHK("fault second reset", 1'b0, fault_n)
    `CHK("rails second reset", 1'b0, rails_enable)
    summarize();
  end
endmodule

`default_nettype wire
